// File: rtc_timekeeper.sv
// Function
// - registers only reached as whole bytes
// - counter and pin-config writes need key 0xEA
// - day flag set on full rollover, clearable
// - bit 6 selects hour wrap 23 or 255
// - wrap select written by any config write, cleared by reset
// - bits 5:4 pick interval time base
// - bit 3 picks periodic or single-shot alarm
// - alarm flag set by hardware, never by write
// - bit 1 low stops and zeroes interval
// - fraction counts 1/128 s, wraps at 127
// - seconds and minutes wrap at 59
// - hour wrap raises clock interrupt
// - interval match sets alarm and interrupt
`default_nettype none
module rtc_timekeeper (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         tick_128hz,
  input  wire rtc_pkg::rtc_bus_t bus,
  output logic [7:0]        rdata,
  output logic [7:0]        irq_pin_config,
  output logic [7:0]        nominal_trim,
  output logic [7:0]        temperature_trim,
  output logic              irq_pulse
);
  // ---------------------------------------------------------------
  // reset release and tick synchroniser
  // ---------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [2:0] tick_sync;
  logic       tick_level;
  logic       tick;

  // reset asserts at once, its release waits two clock edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_sync  <= 3'b000;
      tick_level <= 1'b0;
    end else begin
      tick_sync <= {tick_sync[1:0], tick_128hz};
      // a new level counts once the last two stages agree
      if (tick_sync[2] == tick_sync[1]) begin
        tick_level <= tick_sync[2];
      end
    end
  end

  logic tick_prev;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_prev <= 1'b0;
    end else begin
      tick_prev <= tick_level;
    end
  end
  assign tick = tick_level & ~tick_prev;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] config_reg;
  logic [7:0] fraction_counter;
  logic [7:0] one_hz_counter;
  logic [7:0] per_sixty_s_counter;
  logic [7:0] hours_count;
  logic [7:0] interval_target;
  logic [7:0] unlock_key;
  logic [7:0] interval_count;
  logic       unlocked;
  logic       wr_config;
  rtc_pkg::rtc_ticks_t ticks;
  rtc_pkg::rtc_base_t  base;
  logic       base_tick;
  logic       interval_hit;
  logic [7:0] hour_last;

  function automatic logic wr_at(input rtc_pkg::rtc_bus_t b,
                                 input logic [7:0] a);
    wr_at = b.wr && (b.addr == a);
  endfunction : wr_at

  function automatic logic [7:0] wrap_inc(input logic [7:0] v,
                                          input logic [7:0] last);
    wrap_inc = (v == last) ? 8'h00 : v + 8'h01;
  endfunction : wrap_inc

  // whole-byte writes only, there is no bit path
  assign unlocked  = (unlock_key == rtc_pkg::UNLOCK_VALUE);
  assign wr_config = wr_at(bus, rtc_pkg::ADDR_CONFIG);
  assign hour_last = config_reg[rtc_pkg::BIT_DAY_WRAP] ?
                     rtc_pkg::HOUR_LAST_24 :
                     rtc_pkg::HOUR_LAST_256;

  // ---------------------------------------------------------------
  // cascade of wraps
  // ---------------------------------------------------------------
  assign ticks.frac_wrap = tick &&
    (fraction_counter == rtc_pkg::FRACTION_LAST);
  assign ticks.sec_wrap  = ticks.frac_wrap &&
    (one_hz_counter == rtc_pkg::SIXTY_LAST);
  assign ticks.min_wrap  = ticks.sec_wrap &&
    (per_sixty_s_counter == rtc_pkg::SIXTY_LAST);
  assign ticks.hour_wrap = ticks.min_wrap &&
    (hours_count == hour_last);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_key <= 8'h00;
    end else if (wr_at(bus, rtc_pkg::ADDR_KEY)) begin
      // hardware never clears the key, software owns that
      unlock_key <= bus.wdata;
    end
  end

  // locked writes fall through to normal counting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fraction_counter <= 8'h00;
    end else if (unlocked && wr_at(bus, rtc_pkg::ADDR_FRACTION)) begin
      fraction_counter <= bus.wdata;
    end else if (tick) begin
      fraction_counter <= wrap_inc(fraction_counter,
                                   rtc_pkg::FRACTION_LAST);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      one_hz_counter <= 8'h00;
    end else if (unlocked && wr_at(bus, rtc_pkg::ADDR_SECONDS)) begin
      one_hz_counter <= bus.wdata;
    end else if (ticks.frac_wrap) begin
      one_hz_counter <= wrap_inc(one_hz_counter,
                                 rtc_pkg::SIXTY_LAST);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_sixty_s_counter <= 8'h00;
    end else if (unlocked && wr_at(bus, rtc_pkg::ADDR_MINUTES)) begin
      per_sixty_s_counter <= bus.wdata;
    end else if (ticks.sec_wrap) begin
      per_sixty_s_counter <= wrap_inc(per_sixty_s_counter,
                                      rtc_pkg::SIXTY_LAST);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hours_count <= 8'h00;
    end else if (unlocked && wr_at(bus, rtc_pkg::ADDR_HOURS)) begin
      hours_count <= bus.wdata;
    end else if (ticks.min_wrap) begin
      hours_count <= wrap_inc(hours_count, hour_last);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pin_config <= 8'h00;
    end else if (unlocked && wr_at(bus, rtc_pkg::ADDR_IRQ_PIN)) begin
      irq_pin_config <= bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // plain registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_target <= 8'h00;
    end else if (wr_at(bus, rtc_pkg::ADDR_INTERVAL)) begin
      interval_target <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nominal_trim <= 8'h00;
    end else if (wr_at(bus, rtc_pkg::ADDR_NOM_TRIM)) begin
      nominal_trim <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temperature_trim <= 8'h00;
    end else if (wr_at(bus, rtc_pkg::ADDR_TEMP_TRIM)) begin
      temperature_trim <= bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // interval timer
  // ---------------------------------------------------------------
  assign base = rtc_pkg::rtc_base_t'(
    config_reg[rtc_pkg::BIT_BASE_HI:rtc_pkg::BIT_BASE_LO]);

  always_comb begin
    unique case (base)
      rtc_pkg::RTC_BASE_FRACTION: base_tick = tick;
      rtc_pkg::RTC_BASE_SECOND:   base_tick = ticks.frac_wrap;
      rtc_pkg::RTC_BASE_MINUTE:   base_tick = ticks.sec_wrap;
      rtc_pkg::RTC_BASE_HOUR:     base_tick = ticks.min_wrap;
    endcase
  end

  // single-shot parks here until the run bit drops
  logic shot_done;
  // the 8-bit sum wraps, so a zero target means 256 ticks
  assign interval_hit = config_reg[rtc_pkg::BIT_RUN] && base_tick &&
    !shot_done && (interval_count + 8'h01 == interval_target);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_count <= 8'h00;
      shot_done      <= 1'b0;
    end else if (!config_reg[rtc_pkg::BIT_RUN]) begin
      interval_count <= 8'h00;
      shot_done      <= 1'b0;
    end else if (interval_hit) begin
      interval_count <= 8'h00;
      shot_done      <= config_reg[rtc_pkg::BIT_SINGLE];
    end else if (base_tick && !shot_done) begin
      interval_count <= interval_count + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // configuration and flags; hardware set beats software clear
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_reg <= rtc_pkg::CONFIG_RESET;
    end else begin
      if (wr_config) begin
        config_reg[rtc_pkg::BIT_DAY_WRAP:rtc_pkg::BIT_RUN+1+1] <=
          bus.wdata[rtc_pkg::BIT_DAY_WRAP:rtc_pkg::BIT_RUN+1+1];
        config_reg[rtc_pkg::BIT_RUN]  <= bus.wdata[rtc_pkg::BIT_RUN];
        config_reg[rtc_pkg::BIT_RSVD] <= bus.wdata[rtc_pkg::BIT_RSVD];
        // flags: a written zero clears, a written one keeps
        config_reg[rtc_pkg::BIT_ALARM] <= config_reg[rtc_pkg::BIT_ALARM]
          & bus.wdata[rtc_pkg::BIT_ALARM];
        config_reg[rtc_pkg::BIT_MIDNIGHT] <=
          config_reg[rtc_pkg::BIT_MIDNIGHT]
          & bus.wdata[rtc_pkg::BIT_MIDNIGHT];
      end
      if (ticks.hour_wrap) begin
        config_reg[rtc_pkg::BIT_MIDNIGHT] <= 1'b1;
      end
      if (interval_hit) begin
        config_reg[rtc_pkg::BIT_ALARM] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pulse <= 1'b0;
    end else begin
      // one cycle per event, the flags hold the lasting record
      irq_pulse <= ticks.hour_wrap | interval_hit;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      // read data lags the address by one clock
      unique case (bus.addr)
        rtc_pkg::ADDR_CONFIG:    rdata <= config_reg;
        rtc_pkg::ADDR_FRACTION:  rdata <= fraction_counter;
        rtc_pkg::ADDR_SECONDS:   rdata <= one_hz_counter;
        rtc_pkg::ADDR_MINUTES:   rdata <= per_sixty_s_counter;
        rtc_pkg::ADDR_HOURS:     rdata <= hours_count;
        rtc_pkg::ADDR_INTERVAL:  rdata <= interval_target;
        rtc_pkg::ADDR_KEY:       rdata <= unlock_key;
        rtc_pkg::ADDR_NOM_TRIM:  rdata <= nominal_trim;
        rtc_pkg::ADDR_TEMP_TRIM: rdata <= temperature_trim;
        rtc_pkg::ADDR_IRQ_PIN:   rdata <= irq_pin_config;
        default:                 rdata <= 8'h00;
      endcase
    end
  end
endmodule : rtc_timekeeper
`default_nettype wire

// File: rtc_pkg.sv
`default_nettype none
package rtc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG    = 8'ha1;
  localparam logic [7:0] ADDR_FRACTION  = 8'ha2;
  localparam logic [7:0] ADDR_SECONDS   = 8'ha3;
  localparam logic [7:0] ADDR_MINUTES   = 8'ha4;
  localparam logic [7:0] ADDR_HOURS     = 8'ha5;
  localparam logic [7:0] ADDR_INTERVAL  = 8'ha6;
  localparam logic [7:0] ADDR_KEY       = 8'hc1;
  localparam logic [7:0] ADDR_NOM_TRIM  = 8'hf6;
  localparam logic [7:0] ADDR_TEMP_TRIM = 8'hf7;
  localparam logic [7:0] ADDR_IRQ_PIN   = 8'hff;
  localparam logic [7:0] UNLOCK_VALUE   = 8'hea;

  // ---------------------------------------------------------------
  // config field positions and reset value
  // ---------------------------------------------------------------
  localparam int BIT_MIDNIGHT = 7;
  localparam int BIT_DAY_WRAP = 6;
  localparam int BIT_BASE_HI  = 5;
  localparam int BIT_BASE_LO  = 4;
  localparam int BIT_SINGLE   = 3;
  localparam int BIT_ALARM    = 2;
  localparam int BIT_RUN      = 1;
  localparam int BIT_RSVD     = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h01;

  // ---------------------------------------------------------------
  // wrap points
  // ---------------------------------------------------------------
  localparam logic [7:0] FRACTION_LAST = 8'h7f;
  localparam logic [7:0] SIXTY_LAST    = 8'h3b;
  localparam logic [7:0] HOUR_LAST_24  = 8'h17;
  localparam logic [7:0] HOUR_LAST_256 = 8'hff;

  typedef enum logic [1:0] {
    RTC_BASE_FRACTION = 2'b00,
    RTC_BASE_SECOND   = 2'b01,
    RTC_BASE_MINUTE   = 2'b10,
    RTC_BASE_HOUR     = 2'b11
  } rtc_base_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtc_bus_t;

  typedef struct packed {
    logic frac_wrap;
    logic sec_wrap;
    logic min_wrap;
    logic hour_wrap;
  } rtc_ticks_t;
endpackage : rtc_pkg
`default_nettype wire

// File: rtc_timekeeper_chk.sv
`default_nettype none
module rtc_timekeeper_chk (
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              tick_128hz,
  input wire rtc_pkg::rtc_bus_t bus,
  input wire logic [7:0]        rdata,
  input wire logic [7:0]        irq_pin_config,
  input wire logic [7:0]        nominal_trim,
  input wire logic [7:0]        temperature_trim,
  input wire logic              irq_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] key;
  logic       wr_pin;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ---------------------------------------------------------------
  // shadow of the unlock key
  // ---------------------------------------------------------------
  assign wr_pin = bus.wr && bus.addr == rtc_pkg::ADDR_IRQ_PIN;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) key <= 8'h00;
    else if (bus.wr && bus.addr == rtc_pkg::ADDR_KEY) key <= bus.wdata;
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence s_pin_open;
    wr_pin && key == rtc_pkg::UNLOCK_VALUE;
  endsequence
  property p_pin_open;
    s_pin_open |=> irq_pin_config == $past(bus.wdata);
  endproperty
  property p_pin_lock;
    wr_pin && key != rtc_pkg::UNLOCK_VALUE |=> $stable(irq_pin_config);
  endproperty
  property p_pin_hold;
    !wr_pin |=> $stable(irq_pin_config);
  endproperty
  property p_nom;
    bus.wr && bus.addr == 8'hf6 |=> nominal_trim == $past(bus.wdata);
  endproperty
  property p_temp;
    bus.wr && bus.addr == 8'hf7 |=> temperature_trim == $past(bus.wdata);
  endproperty
  property p_key_rd;
    !bus.wr && bus.addr == rtc_pkg::ADDR_KEY |=> rdata == $past(key);
  endproperty
  property p_unmapped;
    !(bus.addr inside {[8'ha1:8'ha6], 8'hc1, 8'hf6, 8'hf7, 8'hff})
      |=> rdata == 8'h00;
  endproperty
  property p_irq_one;
    irq_pulse |=> !irq_pulse;
  endproperty
  a_pin_open: assert property (p_pin_open)
    else $error("pin config not written while unlocked");
  a_pin_lock: assert property (p_pin_lock)
    else $error("pin config changed while locked");
  a_pin_hold: assert property (p_pin_hold)
    else $error("pin config changed without a write");
  a_nom: assert property (p_nom)
    else $error("nominal trim byte write lost");
  a_temp: assert property (p_temp)
    else $error("temperature trim byte write lost");
  a_key_rd: assert property (p_key_rd)
    else $error("key readback wrong");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address read not zero");
  a_irq_one: assert property (p_irq_one)
    else $error("interrupt pulse longer than one cycle");
endmodule : rtc_timekeeper_chk
bind rtc_timekeeper rtc_timekeeper_chk u_chk (
  .clk(clk), .resetn(resetn), .tick_128hz(tick_128hz), .bus(bus),
  .rdata(rdata), .irq_pin_config(irq_pin_config),
  .nominal_trim(nominal_trim), .temperature_trim(temperature_trim),
  .irq_pulse(irq_pulse));
`default_nettype wire

// File: rtc_timekeeping_interval_alarm_test.sv
`default_nettype none
module rtc_timekeeping_interval_alarm_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, resetn, tick_128hz, irq_pulse;
  rtc_pkg::rtc_bus_t bus;
  logic [7:0]        rdata, irq_pin_config, nominal_trim, temperature_trim;
  int                fails = 0, tests_run = 0, pulses = 0, cycles = 0, b;
  rtc_timekeeper uut (.clk(clk), .resetn(resetn), .tick_128hz(tick_128hz),
    .bus(bus), .rdata(rdata), .irq_pin_config(irq_pin_config),
    .nominal_trim(nominal_trim), .temperature_trim(temperature_trim),
    .irq_pulse(irq_pulse));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) begin
    cycles++;
    if (irq_pulse === 1'b1) pulses++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // bus, tick, check and stop tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    bus = '{1'b1, a, d};
    @(negedge clk);
    bus.wr = 1'b0;
  endtask : wr
  task automatic uw(input logic [7:0] a, d);
    wr(rtc_pkg::ADDR_KEY, rtc_pkg::UNLOCK_VALUE);
    wr(a, d);
    wr(rtc_pkg::ADDR_KEY, 8'h00);
  endtask : uw
  task automatic rd(input logic [7:0] a, exp, input string n);
    @(negedge clk);
    bus.addr = a;
    @(negedge clk);
    chk(n, rdata, exp);
  endtask : rd
  task automatic tk(input int n);
    repeat (n) begin
      @(negedge clk);
      tick_128hz = 1'b1;
      repeat (4) @(negedge clk);
      tick_128hz = 1'b0;
      repeat (8) @(negedge clk);
    end
  endtask : tk
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    tick_128hz = 1'b0;
    bus = '0;
    repeat (6) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    repeat (3) @(negedge clk);
    rd(8'ha1, 8'h01, "config reset");
    rd(8'h10, 8'h00, "unmapped");
    $display("test reset done");
    wr(8'ha3, 8'h10);
    rd(8'ha3, 8'h00, "locked seconds");
    wr(8'hff, 8'h80);
    chk("locked pin", irq_pin_config, 8'h00);
    uw(8'hff, 8'h80);
    chk("open pin", irq_pin_config, 8'h80);
    wr(8'hf6, 8'h5a);
    wr(8'hf7, 8'ha5);
    chk("nominal trim", nominal_trim, 8'h5a);
    chk("temperature trim", temperature_trim, 8'ha5);
    $display("test lock done");
    for (b = 0; b < 2; b++) begin
      uw(8'ha2, 8'h7f);
      uw(8'ha3, 8'h3b);
      uw(8'ha4, 8'h3b);
      uw(8'ha5, b ? 8'h17 : 8'hff);
      wr(8'ha1, {1'b0, b[0], 6'h01});
      pulses = 0;
      tk(1);
      rd(8'ha5, 8'h00, "hour wrap");
      rd(8'ha4, 8'h00, "minute wrap");
      rd(8'ha3, 8'h00, "second wrap");
      rd(8'ha2, 8'h00, "fraction wrap");
      rd(8'ha1, {1'b1, b[0], 6'h01}, "day flag");
      chk("day irq", pulses[7:0], 8'h01);
      wr(8'ha1, {1'b0, b[0], 6'h01});
      rd(8'ha1, {1'b0, b[0], 6'h01}, "day clear");
    end
    $display("test rollover done");
    wr(8'ha6, 8'h03);
    wr(8'ha1, 8'h03);
    pulses = 0;
    tk(6);
    chk("periodic", pulses[7:0], 8'h02);
    rd(8'ha1, 8'h07, "alarm flag");
    wr(8'ha1, 8'h01);
    wr(8'ha1, 8'h0b);
    pulses = 0;
    tk(6);
    chk("single", pulses[7:0], 8'h01);
    wr(8'ha1, 8'h01);
    wr(8'ha1, 8'h03);
    tk(2);
    wr(8'ha1, 8'h01);
    wr(8'ha1, 8'h03);
    pulses = 0;
    tk(2);
    chk("run clears count", pulses[7:0], 8'h00);
    wr(8'ha1, 8'h01);
    tk(3);
    chk("stopped", pulses[7:0], 8'h00);
    wr(8'ha1, 8'h05);
    rd(8'ha1, 8'h01, "alarm not writable");
    $display("test interval done");
    for (b = 0; b < 4; b++) begin
      uw(8'ha2, (b > 0) ? 8'h7e : 8'h00);
      uw(8'ha3, (b > 1) ? 8'h3b : 8'h00);
      uw(8'ha4, (b > 2) ? 8'h3b : 8'h00);
      wr(8'ha6, 8'h01);
      wr(8'ha1, {2'b00, b[1:0], 4'h3});
      pulses = 0;
      tk(2);
      chk("base", pulses[7:0], (b == 0) ? 8'h02 : 8'h01);
      wr(8'ha1, 8'h01);
    end
    for (b = 1; b < 4; b++) begin
      uw(8'ha2, (b > 1) ? 8'h7e : 8'h7d);
      uw(8'ha3, (b > 2) ? 8'h3b : 8'h3a);
      uw(8'ha4, 8'h3a);
      wr(8'ha1, {2'b00, b[1:0], 4'h3});
      pulses = 0;
      tk(2);
      chk("finer base", pulses[7:0], 8'h00);
      wr(8'ha1, 8'h01);
    end
    $display("test base done");
    wr(8'ha1, 8'h41);
    @(negedge clk) resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    rd(8'ha1, 8'h01, "wrap select after power-on");
    $display("test power-on done");
    stop_test();
  end
endmodule : rtc_timekeeping_interval_alarm_test
`default_nettype wire
